// [rtl/pslm_top.sv]
// Functional notes
// - strap code 000 advertises 100 and 10 half duplex; 001, 010 reserved
// - codes 011 and 100 force 10 Mb/s half or full, no negotiation
// - codes 101 and 110 force 100 Mb/s half or full, no negotiation
// - code 111 enables negotiation advertising every ability
// - mode straps on indicator pins are sampled at reset and held
// - indicators flash once, 500 ms period, after reset or soft reset
// - pin pulled high gives active-low indicator, pulled low active-high
// - style input low selects dual indication, high normal indication
// - status pin: strap low shows cable present high, strap high link low
// - mac side supports full mii, reduced mii and serial seven-wire
// - transmit clock to mac runs continuously in mii mode
// - one nibble taken per transmit clock with enable, else ignored
//
// Chosen here: the APB slave port and the register offsets.
`default_nettype none
module pslm_top
  import pslm_pkg::*;
#(
  parameter int FLASH_CYC = FLASH_CYC_DEF,
  parameter int ACT_CYC = ACT_CYC_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [2:0] I_INDICATOR_PIN,
  output logic [2:0] O_INDICATOR_OUT,
  output logic [2:0] O_INDICATOR_OE_B,
  input wire logic I_CABLE_OR_LINK_STATUS_IN,
  output logic O_CABLE_OR_LINK_STATUS_OUT,
  output logic O_CABLE_OR_LINK_STATUS_OE_B,
  input wire logic I_INDICATOR_STYLE_PIN,
  input wire logic I_LINK_UP,
  input wire logic I_CABLE_PRESENT,
  input wire logic I_COLLISION,
  input wire logic I_RX_ACTIVITY,
  input wire logic I_NEG_SPEED100,
  input wire logic I_NEG_FULL_DUPLEX,
  output logic O_ANEG_EN,
  output logic [3:0] O_ADV_ABILITY,
  output logic O_SPEED100,
  output logic O_FULL_DUPLEX,
  output logic [1:0] O_MAC_MODE,
  input wire logic [3:0] I_TXD,
  input wire logic I_TX_EN,
  input wire logic I_TX_ER,
  output logic O_TX_CLK,
  output logic O_NIB_VALID,
  output pslm_nib_s O_NIB_DATA,
  input wire logic I_NIB_READY
);
  localparam int FW = $clog2(FLASH_CYC);
  localparam int HALF = FLASH_CYC / 2;
  localparam int ACW = $clog2(ACT_CYC + 1);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  localparam int DW = $clog2(TXDIV);

  logic [10:0] pin_s;
  logic [2:0] ind_s;
  logic txen_s;
  logic txer_s;
  logic [3:0] txd_s;
  pslm_led_e st;
  logic [FW-1:0] flash_cnt;
  logic [2:0] strap;
  logic cls_mode;
  pslm_cfg_s cfg;
  logic sp100_q;
  logic full_q;
  logic soft_rst;
  logic [1:0] mac_mode;
  logic ovf;
  logic [DW-1:0] div;
  logic tick;
  logic [2:0] part;
  logic [1:0] pcnt;
  logic push_v;
  pslm_nib_s push_d;
  logic push_rdy;
  logic [LW-1:0] lvl;
  logic [ACW-1:0] act_cnt;
  logic act_on;
  logic [2:0] led_on;
  logic setup;
  logic wr;
  logic hit;
  logic slverr;
  logic [31:0] rd_word;

  // the strap, style, status and transmit pins pass two flops first
  pslm_sync #(.W(11)) u_sync (
    .i_clk(I_REF_CLK),
    .i_rst_b(I_RST_B),
    .i_d({I_TX_ER, I_TX_EN, I_TXD, I_INDICATOR_STYLE_PIN,
          I_CABLE_OR_LINK_STATUS_IN, I_INDICATOR_PIN}),
    .o_q(pin_s)
  );
  assign ind_s = pin_s[2:0];
  assign txd_s = pin_s[8:5];
  assign txen_s = pin_s[9];
  assign txer_s = pin_s[10];

  // wait for syncs to fill, latch straps, flash, then run
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      st <= ST_WAIT;
      flash_cnt <= '0;
    end else begin
      case (st)
        ST_WAIT: begin
          flash_cnt <= flash_cnt + 1'b1;
          if (flash_cnt == FW'(STRAP_WAIT - 1)) begin
            st <= ST_ON;
            flash_cnt <= '0;
          end
        end
        ST_ON, ST_OFF: begin
          flash_cnt <= flash_cnt + 1'b1;
          if (soft_rst) begin
            st <= ST_ON;
            flash_cnt <= '0;
          end else if (flash_cnt == FW'(HALF - 1)) begin
            st <= (st == ST_ON) ? ST_OFF : ST_RUN;
            flash_cnt <= '0;
          end
        end
        ST_RUN: begin
          if (soft_rst) begin
            st <= ST_ON;
            flash_cnt <= '0;
          end
        end
        default: begin
          st <= ST_WAIT;
          flash_cnt <= '0;
        end
      endcase
    end
  end

  // straps caught once, after release, while the pins are still undriven
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      strap <= STRAP_RST;
      cls_mode <= CLS_MODE_RST;
    end else if (st == ST_WAIT && flash_cnt == FW'(STRAP_WAIT - 1)) begin
      strap <= ind_s;
      cls_mode <= pin_s[3];
    end
  end

  // strap code to negotiation and forced mode
  always_comb begin
    cfg = '0;
    case (strap)
      CODE_DUAL_HDX: begin
        cfg.aneg = 1'b1;
        cfg.adv = ADV_DUAL;
      end
      CODE_10_HDX: cfg.full = 1'b0;
      CODE_10_FDX: cfg.full = 1'b1;
      CODE_100_HDX: cfg.sp100 = 1'b1;
      CODE_100_FDX: begin
        cfg.sp100 = 1'b1;
        cfg.full = 1'b1;
      end
      CODE_ALL: begin
        cfg.aneg = 1'b1;
        cfg.adv = ADV_ALL;
      end
      default: begin
        // reserved codes fall back to the dual-speed half-duplex setting
        cfg.aneg = 1'b1;
        cfg.adv = ADV_DUAL;
        cfg.resv = 1'b1;
      end
    endcase
  end

  // resolved mode: negotiated result only when negotiation is on
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_ANEG_EN <= 1'b0;
      O_ADV_ABILITY <= 4'h0;
      sp100_q <= 1'b0;
      full_q <= 1'b0;
    end else begin
      O_ANEG_EN <= cfg.aneg;
      O_ADV_ABILITY <= cfg.adv;
      sp100_q <= cfg.aneg ? I_NEG_SPEED100 : cfg.sp100;
      full_q <= cfg.aneg ? I_NEG_FULL_DUPLEX : cfg.full;
    end
  end
  assign O_SPEED100 = sp100_q;
  assign O_FULL_DUPLEX = full_q;
  assign O_MAC_MODE = mac_mode;

  // activity stretch: load only when idle so steady traffic still blinks
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      act_cnt <= '0;
    end else if (act_cnt != '0) begin
      act_cnt <= act_cnt - 1'b1;
    end else if (push_v || I_RX_ACTIVITY) begin
      act_cnt <= ACW'(ACT_CYC - 1);
    end
  end
  assign act_on = (act_cnt >= ACW'(ACT_CYC / 2));

  // indicator meaning, bit0 = a, bit1 = b, bit2 = c
  always_comb begin
    led_on = 3'h0;
    if (st == ST_ON) begin
      led_on = 3'h7;
    end else if (st == ST_RUN) begin
      if (pin_s[4]) begin
        led_on = {act_on, sp100_q, full_q};
      end else begin
        led_on[0] = I_LINK_UP & (sp100_q ^ act_on);
        led_on[1] = I_LINK_UP & ~sp100_q;
        led_on[2] = full_q | (I_COLLISION & act_on);
      end
    end
  end

  // pins stay released until the straps are caught
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_INDICATOR_OUT <= 3'h0;
      O_INDICATOR_OE_B <= 3'h7;
      O_CABLE_OR_LINK_STATUS_OUT <= 1'b0;
      O_CABLE_OR_LINK_STATUS_OE_B <= 1'b1;
    end else begin
      O_INDICATOR_OUT <= led_on ^ strap;
      O_INDICATOR_OE_B <= {3{st == ST_WAIT}};
      O_CABLE_OR_LINK_STATUS_OUT <= cls_mode ? ~I_LINK_UP : I_CABLE_PRESENT;
      O_CABLE_OR_LINK_STATUS_OE_B <= (st == ST_WAIT);
    end
  end

  // transmit clock divider, rises when div wraps to zero
  assign tick = (div == DW'(TXDIV - 1));
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      div <= '0;
      O_TX_CLK <= 1'b0;
    end else begin
      div <= tick ? '0 : div + 1'b1;
      if (tick) begin
        O_TX_CLK <= (mac_mode != MODE_RMII);
      end else if (div == DW'(TXDIV / 2 - 1)) begin
        O_TX_CLK <= 1'b0;
      end
    end
  end

  // sampled just before the next rise: the mac moved its lines after the last one
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      part <= 3'h0;
      pcnt <= 2'h0;
    end else if (tick) begin
      if (!txen_s) begin
        pcnt <= 2'h0;
      end else begin
        pcnt <= pcnt + 1'b1;
        if (mac_mode == MODE_RMII) begin
          part[1:0] <= txd_s[1:0];
        end else begin
          part <= {txd_s[0], part[2:1]};
        end
      end
    end
  end

  // nibble assembly per mac mode; a partial nibble at enable drop is dropped
  always_comb begin
    push_v = 1'b0;
    push_d = '0;
    if (tick && txen_s) begin
      case (mac_mode)
        MODE_RMII: begin
          push_v = pcnt[0];
          push_d.d = {txd_s[1:0], part[1:0]};
        end
        MODE_SERIAL7: begin
          push_v = (pcnt == 2'h3);
          push_d.d = {txd_s[0], part};
        end
        default: begin
          push_v = 1'b1;
          push_d.d = txd_s;
          push_d.er = txer_s;
        end
      endcase
    end
  end

  pslm_fifo #(.W($bits(pslm_nib_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(I_REF_CLK),
    .i_rst_b(I_RST_B),
    .i_in_valid(push_v),
    .i_in_data(push_d),
    .o_in_ready(push_rdy),
    .o_out_valid(O_NIB_VALID),
    .o_out_data(O_NIB_DATA),
    .i_out_ready(I_NIB_READY),
    .o_level(lvl)
  );

  // apb: zero wait, read data captured in the setup cycle
  assign setup = I_PSEL & ~I_PENABLE;
  assign wr = I_PSEL & I_PENABLE & I_PWRITE;
  assign hit = (I_PADDR == ADDR_CTRL) | (I_PADDR == ADDR_STAT) | (I_PADDR == ADDR_EVT);
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = slverr & I_PSEL & I_PENABLE;

  always_comb begin
    rd_word = 32'h0;
    case (I_PADDR)
      ADDR_CTRL: rd_word[CTRL_MODE_LSB +: 2] = mac_mode;
      ADDR_STAT: begin
        rd_word[STAT_CODE_LSB +: 3] = strap;
        rd_word[STAT_CFG_LSB +: 8] = cfg;
        rd_word[STAT_CLS] = cls_mode;
        rd_word[STAT_STYLE] = pin_s[4];
        rd_word[STAT_SPD] = sp100_q;
        rd_word[STAT_FDX] = full_q;
        rd_word[STAT_LVL_LSB +: LW] = lvl;
      end
      ADDR_EVT: rd_word[EVT_OVF] = ovf;
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PRDATA <= 32'h0;
      slverr <= 1'b0;
    end else if (setup) begin
      O_PRDATA <= I_PWRITE ? 32'h0 : rd_word;
      slverr <= ~hit;
    end
  end

  // control: soft reset is a one-cycle pulse, never read back
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      soft_rst <= 1'b0;
      mac_mode <= MODE_RST;
    end else begin
      soft_rst <= wr && I_PADDR == ADDR_CTRL && I_PWDATA[CTRL_SRST];
      if (wr && I_PADDR == ADDR_CTRL) begin
        mac_mode <= I_PWDATA[CTRL_MODE_LSB +: 2];
      end
    end
  end

  // overflow sticky, write one to clear; a new overflow beats the clear
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ovf <= 1'b0;
    end else if (push_v && !push_rdy) begin
      ovf <= 1'b1;
    end else if (wr && I_PADDR == ADDR_EVT && I_PWDATA[EVT_OVF]) begin
      ovf <= 1'b0;
    end
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);

  sequence s_flash_end;
    st == ST_ON && !soft_rst && flash_cnt == FW'(HALF - 1);
  endsequence
  sequence s_clk_wave;
    O_TX_CLK [*4] ##1 !O_TX_CLK [*3];
  endsequence

  a_flash_dark: assert property (s_flash_end |=> st == ST_OFF ##1 O_INDICATOR_OUT == strap)
    else $error("indicators not dark after flash half");
  a_flash_lit: assert property (st == ST_ON |=> O_INDICATOR_OUT == ~strap && O_INDICATOR_OE_B == 3'h0)
    else $error("flash level not opposite to strap");
  a_strap_take: assert property (st == ST_WAIT && flash_cnt == FW'(STRAP_WAIT - 1)
    |=> strap == $past(ind_s))
    else $error("strap not latched from pins");
  a_dual_half: assert property (st == ST_RUN && strap == CODE_DUAL_HDX
    |-> O_ANEG_EN && O_ADV_ABILITY == ADV_DUAL)
    else $error("code 000 advertises wrong abilities");
  a_force_ten: assert property (st == ST_RUN && (strap == CODE_10_HDX || strap == CODE_10_FDX)
    |-> !O_ANEG_EN && !O_SPEED100 && O_FULL_DUPLEX == (strap == CODE_10_FDX))
    else $error("forced 10 mode wrong");
  a_force_hundred: assert property (st == ST_RUN && (strap == CODE_100_HDX || strap == CODE_100_FDX)
    |-> !O_ANEG_EN && O_SPEED100 && O_FULL_DUPLEX == (strap == CODE_100_FDX))
    else $error("forced 100 mode wrong");
  a_aneg_all: assert property (st == ST_RUN && strap == CODE_ALL
    |-> O_ANEG_EN && O_ADV_ABILITY == ADV_ALL)
    else $error("code 111 does not advertise all");
  a_link_status: assert property (st == ST_RUN && cls_mode
    |=> O_CABLE_OR_LINK_STATUS_OUT == !$past(I_LINK_UP))
    else $error("link status pin level wrong");
  a_normal_duplex: assert property (st == ST_RUN && pin_s[4] && !soft_rst
    |=> O_INDICATOR_OUT[0] == ($past(full_q) ^ strap[0]))
    else $error("indicator a does not show duplex");
  a_txclk_wave: assert property ($rose(O_TX_CLK) |-> s_clk_wave)
    else $error("transmit clock shape wrong");
  a_txclk_run: assert property (mac_mode != MODE_RMII && $past(mac_mode) != MODE_RMII
    && $fell(O_TX_CLK) |-> ##4 (O_TX_CLK || mac_mode == MODE_RMII))
    else $error("transmit clock stopped in mii mode");
  a_rmii_quiet: assert property (mac_mode == MODE_RMII && !O_TX_CLK |=> !O_TX_CLK)
    else $error("transmit clock runs in reduced mode");
  a_nib_take: assert property (tick && txen_s && mac_mode == MODE_MII
    |-> push_v && push_d == {txer_s, txd_s})
    else $error("nibble not taken with enable");
  a_idle_ignore: assert property (!txen_s |-> !push_v)
    else $error("nibble taken without enable");
endmodule
`default_nettype wire

// [rtl/pslm_pkg.sv]
`default_nettype none
package pslm_pkg;
  // timing, printed figures first, cycle counts derived from the 10 MHz reference
  localparam int REF_CLK_NS = 100;
  localparam int TXCLK_NS = 800;
  localparam int TXDIV = TXCLK_NS / REF_CLK_NS;
  localparam int FLASH_MS = 500;
  localparam int FLASH_CYC_DEF = FLASH_MS * 1000000 / REF_CLK_NS;
  localparam int ACT_MS = 50;
  localparam int ACT_CYC_DEF = ACT_MS * 1000000 / REF_CLK_NS;
  localparam int STRAP_WAIT = 4;
  localparam int FIFO_DEPTH_DEF = 32;

  // register map, byte addresses on the apb
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_EVT = 8'h08;
  localparam int CTRL_SRST = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int STAT_CODE_LSB = 0;
  localparam int STAT_CFG_LSB = 3;
  localparam int STAT_CLS = 11;
  localparam int STAT_STYLE = 12;
  localparam int STAT_SPD = 13;
  localparam int STAT_FDX = 14;
  localparam int STAT_LVL_LSB = 16;
  localparam int EVT_OVF = 0;
  localparam logic [1:0] MODE_RST = 2'h0;

  // mac-side pin modes
  localparam logic [1:0] MODE_MII = 2'h0;
  localparam logic [1:0] MODE_RMII = 2'h1;
  localparam logic [1:0] MODE_SERIAL7 = 2'h2;

  // mode strap codes {bit2, bit1, bit0}
  localparam logic [2:0] CODE_DUAL_HDX = 3'h0;
  localparam logic [2:0] CODE_10_HDX = 3'h3;
  localparam logic [2:0] CODE_10_FDX = 3'h4;
  localparam logic [2:0] CODE_100_HDX = 3'h5;
  localparam logic [2:0] CODE_100_FDX = 3'h6;
  localparam logic [2:0] CODE_ALL = 3'h7;
  localparam logic [2:0] STRAP_RST = 3'h7;
  localparam logic CLS_MODE_RST = 1'h0;

  // ability bits: [3] 100 full, [2] 100 half, [1] 10 full, [0] 10 half
  localparam logic [3:0] ADV_DUAL = 4'h5;
  localparam logic [3:0] ADV_ALL = 4'hF;

  typedef enum logic [3:0] {
    ST_WAIT = 4'h1,
    ST_ON = 4'h2,
    ST_OFF = 4'h4,
    ST_RUN = 4'h8
  } pslm_led_e;

  typedef struct packed {
    logic er;
    logic [3:0] d;
  } pslm_nib_s;

  typedef struct packed {
    logic aneg;
    logic [3:0] adv;
    logic sp100;
    logic full;
    logic resv;
  } pslm_cfg_s;
endpackage
`default_nettype wire

// [rtl/pslm_sync.sv]
`default_nettype none
module pslm_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  // two-stage synchroniser, meta is read only by o_q
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule
`default_nettype wire

// [rtl/pslm_fifo.sv]
`default_nettype none
module pslm_fifo #(
  parameter int W = 5,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready,
  output logic [$clog2(DEPTH):0] o_level
);
  localparam int AW = $clog2(DEPTH);
  // depth must be a power of two: pointers wrap on their low bits
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  // extra pointer bit tells full from empty
  assign o_level = wr_ptr - rd_ptr;
  assign o_in_ready = (o_level != (AW+1)'(DEPTH));
  assign o_out_valid = (wr_ptr != rd_ptr);
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem[rd_ptr[AW-1:0]];

  // pointers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // storage, no reset needed: read only behind valid
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end
endmodule
`default_nettype wire

// [tb/pslm_mac_model.sv]
`default_nettype none
module pslm_mac_model (
  input wire logic i_clk,
  input wire logic i_tx_clk,
  output logic [3:0] o_txd,
  output logic o_tx_en,
  output logic o_tx_er
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev = 1'b0;
  logic [2:0] ph = 3'h0;
  // phase follows tx clock rises, free-runs while that clock is held low
  always @(posedge i_clk) begin
    prev <= i_tx_clk;
    ph <= (i_tx_clk && !prev) ? 3'h1 : ph + 3'h1;
  end
  // idle lines before the first frame
  initial begin
    o_txd = 4'hA;
    o_tx_en = 1'b0;
    o_tx_er = 1'b0;
  end
  // one unit per period, changed just after the clock rise
  task automatic send(input logic [4:0] q[$]);
    foreach (q[i]) begin
      @(posedge i_clk);
      while (ph != 3'h0) @(posedge i_clk);
      o_tx_en <= 1'b1;
      {o_tx_er, o_txd} <= q[i];
    end
    @(posedge i_clk);
    while (ph != 3'h0) @(posedge i_clk);
    o_tx_en <= 1'b0;
    // released lines show the inverse so stale data cannot pass
    {o_tx_er, o_txd} <= ~q[q.size()-1];
  endtask
endmodule
`default_nettype wire

// [tb/pslm_top_tb_top.sv]
`default_nettype none
module pslm_top_tb_top
  import pslm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FL = 40;
  localparam int AC = 20;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] strap = 3'h7;
  logic cls = 1'b0;
  logic [2:0] out;
  logic [2:0] oe_b;
  logic [2:0] pin;
  logic cls_out;
  logic cls_oe_b;
  logic cls_pin;
  logic style = 1'b1;
  logic act = 1'b0;
  logic link = 1'b1;
  logic cable = 1'b1;
  logic aneg;
  logic [3:0] adv;
  logic spd;
  logic fd;
  logic [1:0] mode;
  logic [3:0] txd;
  logic txen;
  logic txer;
  logic txclk;
  logic nv;
  pslm_nib_s nd;
  logic nr = 1'b1;
  logic [31:0] rv;
  logic ev;
  logic [4:0] got[$];
  logic [4:0] q[$];
  logic [4:0] e[$];
  int n;
  int error_cnt = 0;
  int checked = 0;

  always #50 clk = ~clk;
  // pads: pull level while released, device drive otherwise
  assign pin = (oe_b & strap) | (~oe_b & out);
  assign cls_pin = cls_oe_b ? cls : cls_out;

  pslm_top #(.FLASH_CYC(FL), .ACT_CYC(AC), .FIFO_DEPTH(32)) pslm_top_i (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_INDICATOR_PIN(pin),
    .O_INDICATOR_OUT(out), .O_INDICATOR_OE_B(oe_b),
    .I_CABLE_OR_LINK_STATUS_IN(cls_pin), .O_CABLE_OR_LINK_STATUS_OUT(cls_out),
    .O_CABLE_OR_LINK_STATUS_OE_B(cls_oe_b), .I_INDICATOR_STYLE_PIN(style),
    .I_LINK_UP(link), .I_CABLE_PRESENT(cable), .I_COLLISION(1'b0),
    .I_RX_ACTIVITY(act), .I_NEG_SPEED100(1'b1), .I_NEG_FULL_DUPLEX(1'b1),
    .O_ANEG_EN(aneg), .O_ADV_ABILITY(adv), .O_SPEED100(spd), .O_FULL_DUPLEX(fd),
    .O_MAC_MODE(mode), .I_TXD(txd), .I_TX_EN(txen), .I_TX_ER(txer),
    .O_TX_CLK(txclk), .O_NIB_VALID(nv), .O_NIB_DATA(nd), .I_NIB_READY(nr));

  pslm_mac_model pslm_mac_model_i (.i_clk(clk), .i_tx_clk(txclk), .o_txd(txd),
    .o_tx_en(txen), .o_tx_er(txer));

  // collect every nibble handed over on the stream
  always @(posedge clk) if (nv === 1'b1 && nr === 1'b1) got.push_back(nd);

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, g, x);
    end
  endtask

  task automatic cmpq();
    chk(got.size(), e.size());
    foreach (e[i]) if (i < got.size()) chk(got[i], e[i]);
    got.delete();
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask

  // one apb transfer; no wait-state count assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // a slave that never answers is caught by the watchdog
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // hardware reset with given straps, then wait for the pins to be driven
  task automatic boot(input logic [2:0] s, input logic c);
    int k = 0;
    strap <= s;
    cls <= c;
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    @(posedge clk);
    while (oe_b !== 3'h0 && k < 20) begin
      k++;
      @(posedge clk);
    end
    chk(out, 3'(~s));
  endtask

  task automatic hi();
    n = 0;
    repeat (16) begin
      @(posedge clk);
      n += (txclk === 1'b1);
    end
  endtask

  function automatic logic [6:0] ex(input logic [2:0] c);
    case (c)
      CODE_10_HDX: return 7'h00;
      CODE_10_FDX: return 7'h01;
      CODE_100_HDX: return 7'h02;
      CODE_100_FDX: return 7'h03;
      CODE_ALL: return {1'b1, ADV_ALL, 2'h3};
      default: return {1'b1, ADV_DUAL, 2'h3};
    endcase
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog: the whole sequence needs about 1100 cycles
  initial begin
    cyc(20000);
    error_cnt++;
    summarize();
  end

  // main sequence
  initial begin
    for (int c = 0; c < 8; c++) begin
      link <= c[1];
      cable <= c[2];
      boot(c[2:0], c[0]);
      cyc(2);
      chk({aneg, adv & {4{aneg}}, spd, fd}, ex(c[2:0]));
      chk(cls_out, c[0] ? !c[1] : c[2]);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rv[3:0], {(c == 1 || c == 2), c[2:0]});
      // reach the run state so the mode properties see codes 000 and 011 to 111 and the status-pin one the odd codes
      cyc(FL);
    end
    link <= 1'b1;
    cable <= 1'b1;
    // flash then normal run values, forced 100 half duplex
    boot(3'h5, 1'b0);
    cyc(FL / 2 + 1);
    chk(out, 3'h5);
    cyc(FL / 2 + 2);
    chk(out, 3'h2 ^ 3'h5);
    act <= 1'b1;
    cyc(1);
    act <= 1'b0;
    cyc(3);
    chk(out[2], 1'b0);
    style <= 1'b0;
    cyc(AC + 6);
    chk(out, 3'h1 ^ 3'h5);
    style <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h1);
    cyc(3);
    chk(out, 3'h2);
    // unmapped place is refused
    apb(1'b0, 8'h0C, 32'h0);
    chk(ev, 1'b1);
    chk(rv, 32'h0);
    // reduced mii: clock held low, dibits paired low first
    apb(1'b1, ADDR_CTRL, {29'h0, MODE_RMII, 1'b0});
    // mode lands at the access edge; a high phase already begun still ends
    cyc(8);
    chk(mode, MODE_RMII);
    hi();
    chk(n, 0);
    q = '{5'h01, 5'h02, 5'h03, 5'h00};
    pslm_mac_model_i.send(q);
    cyc(20);
    e = '{5'h09, 5'h03};
    cmpq();
    // serial seven-wire: four bits per nibble, first bit lowest
    apb(1'b1, ADDR_CTRL, {29'h0, MODE_SERIAL7, 1'b0});
    q = '{5'h01, 5'h00, 5'h01, 5'h01};
    pslm_mac_model_i.send(q);
    cyc(20);
    e = '{5'h0D};
    cmpq();
    // full mii: fill the buffer past full with the consumer stalled
    apb(1'b1, ADDR_CTRL, {29'h0, MODE_MII, 1'b0});
    hi();
    chk(n, 8);
    nr <= 1'b0;
    q.delete();
    e.delete();
    for (int i = 0; i < 34; i++) q.push_back(i[4:0]);
    for (int i = 0; i < 32; i++) e.push_back(i[4:0]);
    pslm_mac_model_i.send(q);
    cyc(4);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rv[STAT_LVL_LSB +: 6], 32'h20);
    apb(1'b0, ADDR_EVT, 32'h0);
    chk(rv[EVT_OVF], 1'b1);
    apb(1'b1, ADDR_EVT, 32'h1);
    apb(1'b0, ADDR_EVT, 32'h0);
    chk(rv[EVT_OVF], 1'b0);
    nr <= 1'b1;
    cyc(40);
    cmpq();
    summarize();
  end
endmodule
`default_nettype wire
